/* File: ats_regs.svh */
// Purpose: register offsets, reset values and fixed-point constants of the sampler
// Assumes: 8-bit byte offsets inside the slave window, 4.4 / 8.4 fixed point
// Notes:   definitions only
`ifndef ATS_REGS_SVH
`define ATS_REGS_SVH
`define ATS_OFS_LIMIT   8'h00
`define ATS_OFS_FILTER  8'h04
`define ATS_OFS_LEVELS  8'h08
`define ATS_OFS_LODCLMP 8'h0C
`define ATS_OFS_CEILING 8'h10
`define ATS_OFS_STATUS  8'h14
`define ATS_ONE         12'h010
`define ATS_TWO         12'h020
`define ATS_RST_LIMIT   12'h010
`define ATS_RST_FILTER  1'h1
`define ATS_RST_LEVELS  8'hF0
`define ATS_RST_LODCLMP 16'h7F80
`define ATS_HALF        14'h0080
`define ATS_STEP_N1     8'h80
`define ATS_STEP_N2     8'h55
`define ATS_STEP_N4     8'h33
`define ATS_STEP_N8     8'h1C
`define ATS_STEP_N16    8'h0F
`define ATS_LOD_BIAS    10'h080
`endif

/* File: ats_pkg.sv */
// Purpose: types shared by the anisotropic sampler and its bench
// Assumes: derivatives and coordinates are 8.8 fixed point
// Notes:   constants live in ats_regs.svh
package ats_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CALC, ST_ISSUE, ST_WAIT, ST_DONE} ats_state_e;
  typedef struct packed {
    logic signed [15:0] dudx;
    logic signed [15:0] dvdx;
    logic signed [15:0] dudy;
    logic signed [15:0] dvdy;
    logic        [15:0] u;
    logic        [15:0] v;
  } ats_frag_s;
  typedef struct packed {
    logic [15:0] u;
    logic [15:0] v;
    logic [3:0]  level;
  } ats_fetch_s;
endpackage

/* File: ats_sampler.sv */
// Purpose: anisotropic texture sampler with AHB-Lite configuration registers
// Assumes: one fragment in flight; texel answers come in request order
// Notes:   sample counts are powers of two; lod is truncated to pick the fetched mip level
// Functional notes
// - a limit of exactly one gives plain isotropic filtering with one sample
// - a limit above one filters anisotropically up to min of limit and ceiling
// - levels other than base are read only with a mipmapped minify filter
// - with mipmapping only levels base through max level are accessed
// - min and max level-of-detail clamps are honoured
// - the reported implementation ceiling is at least two
// - two scale factors are computed, one per screen axis
// - count is min of ceil ratio and limit; lod is log2 of Pmax over count
// - the count may be rounded to a supported power of two
// - approximate scale factors lie between max and sum of abs derivatives
// - N samples at the computed lod are averaged with equal weights
// - above one the averaged multi-sample value is the fragment result
// - samples sit along the major axis at offsets i/(N+1) minus one half
// - filter settings may steer the scheme, e.g. two taps for nearest
// - filter settings may be ignored in favour of best quality
`include "ats_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module ats_sampler #(
  parameter logic [11:0] CEILING = 12'h100, // implementation_aniso_ceiling, 8.4
  parameter int          MAX_K   = 4        // log2 of largest sample count
) (
  input  wire logic               hclk,        // bus and core clock
  input  wire logic               hresetn,     // async reset, active low
  input  wire logic               hsel,        // slave select
  input  wire logic [31:0]        haddr,       // byte address
  input  wire logic [1:0]         htrans,      // transfer type
  input  wire logic               hwrite,      // write access
  input  wire logic [2:0]         hsize,       // transfer size
  input  wire logic [31:0]        hwdata,      // write data
  input  wire logic               hready,      // bus ready in
  output logic                    hreadyout,   // slave ready
  output logic                    hresp,       // always okay
  output logic [31:0]             hrdata,      // read data
  input  wire logic               frag_valid,  // fragment offered
  input  wire ats_pkg::ats_frag_s frag,        // derivatives and centre
  output logic                    frag_ready,  // fragment taken
  output logic                    fetch_valid, // texel fetch request
  output ats_pkg::ats_fetch_s     fetch,       // fetch position and level
  input  wire logic               fetch_ready, // fetch taken
  input  wire logic               texel_valid, // texel answer
  input  wire logic [31:0]        texel_data,  // four 8-bit channels
  output logic                    result_valid, // filtered value ready
  output logic [31:0]             result_data,  // filtered value
  input  wire logic               result_ready  // result taken
);
  // bus and register state
  logic        ap_valid, next_ap_valid;
  logic        ap_write, next_ap_write;
  logic [7:0]  ap_addr, next_ap_addr;
  logic [31:0] next_hrdata;
  logic [11:0] limit, next_limit;
  logic        mip, next_mip;
  logic [7:0]  levels, next_levels;
  logic [15:0] lodclmp, next_lodclmp;
  // datapath state
  ats_pkg::ats_state_e st, next_st;
  ats_pkg::ats_frag_s  f, next_f;
  logic [2:0]          k, next_k;
  logic [3:0]          lvl, next_lvl;
  logic signed [7:0]   lod, next_lod;
  logic                axis_x, next_axis_x;
  logic [16:0]         pm, next_pm;
  logic [4:0]          idx, next_idx;
  logic [47:0]         acc, next_acc;
  logic [31:0]         next_result;
  // combinational terms
  logic [16:0]         px, py, pmax, pmin;
  logic [11:0]         eff;
  logic                iso;
  logic [2:0]          kmax, kc;
  logic [4:0]          pos;
  logic [3:0]          frac;
  logic signed [9:0]   lod_w;
  logic signed [7:0]   lod_c, lod_min, lod_max;
  logic [4:0]          lvl_w;
  logic [7:0]          step;
  logic signed [13:0]  off;
  logic signed [29:0]  du, dv;
  logic [20:0]         sh;
  logic [16:0]         norm;

  function automatic logic [15:0] ats_abs(input logic signed [15:0] x);
    return x[15] ? 16'(-x) : 16'(x);
  endfunction

  // max plus half of min: continuous, monotonic, between max and sum
  function automatic logic [16:0] ats_scale(input logic signed [15:0] a,
                                            input logic signed [15:0] b);
    logic [15:0] ma, mb, hi, lo;
    ma = ats_abs(a);
    mb = ats_abs(b);
    hi = (ma > mb) ? ma : mb;
    lo = (ma > mb) ? mb : ma;
    return {1'b0, hi} + {2'b00, lo[15:1]};
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    next_ap_valid = hsel & htrans[1] & hready & (hsize == 3'h2);
    next_ap_write = hwrite;
    next_ap_addr  = haddr[7:0];
    next_limit    = limit;
    next_mip      = mip;
    next_levels   = levels;
    next_lodclmp  = lodclmp;
    next_hrdata   = 32'h0;
    if (ap_valid && ap_write)
    begin
      unique case (ap_addr)
        `ATS_OFS_LIMIT:   next_limit   = hwdata[11:0];
        `ATS_OFS_FILTER:  next_mip     = hwdata[0];
        `ATS_OFS_LEVELS:  next_levels  = hwdata[7:0];
        `ATS_OFS_LODCLMP: next_lodclmp = hwdata[15:0];
        default:          next_mip     = mip;
      endcase
    end
    if (next_ap_valid && !hwrite)
    begin
      unique case (haddr[7:0])
        `ATS_OFS_LIMIT:   next_hrdata = {20'h0, limit};
        `ATS_OFS_FILTER:  next_hrdata = {31'h0, mip};
        `ATS_OFS_LEVELS:  next_hrdata = {24'h0, levels};
        `ATS_OFS_LODCLMP: next_hrdata = {16'h0, lodclmp};
        `ATS_OFS_CEILING: next_hrdata = {20'h0, CEILING};
        `ATS_OFS_STATUS:  next_hrdata = {8'h0, lod, 1'b0, k, lvl, 7'h0, st != ats_pkg::ST_IDLE};
        default:          next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
      hrdata   <= 32'h0;
      limit    <= `ATS_RST_LIMIT;
      mip      <= `ATS_RST_FILTER;
      levels   <= `ATS_RST_LEVELS;
      lodclmp  <= `ATS_RST_LODCLMP;
    end
    else
    begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr  <= next_ap_addr;
      hrdata   <= next_hrdata;
      limit    <= next_limit;
      mip      <= next_mip;
      levels   <= next_levels;
      lodclmp  <= next_lodclmp;
    end
  end

  always_comb
  begin
    px   = ats_scale(f.dudx, f.dvdx);
    py   = ats_scale(f.dudy, f.dvdy);
    pmax = (px > py) ? px : py;
    pmin = (px > py) ? py : px;
    eff  = (limit < CEILING) ? limit : CEILING;
    iso  = (limit <= `ATS_ONE);
    kmax = 3'h0;
    for (int j = 1; j <= MAX_K; j++)
      if ({4'h0, eff[11:4]} >= (12'h1 << j))
        kmax = 3'(j);
    // smallest power of two not below the ratio, capped by the limit
    kc = kmax;
    for (int j = MAX_K; j >= 0; j--)
    begin
      sh = {4'h0, pmin} << j;
      if (3'(j) <= kmax && sh >= {4'h0, pmax})
        kc = 3'(j);
    end
    if (iso)
      kc = 3'h0;
    pos = 5'h0;
    for (int b = 0; b < 17; b++)
      if (pmax[b])
        pos = 5'(b);
    norm  = pmax << (5'd16 - pos);
    frac  = norm[15:12];
    lod_w = $signed({1'b0, pos, frac}) - $signed(`ATS_LOD_BIAS)
            - $signed({3'h0, kc, 4'h0});
    if (pmax == 17'h0)
      lod_w = -10'sd128;
    lod_min = $signed(lodclmp[7:0]);
    lod_max = $signed(lodclmp[15:8]);
    lod_c = (lod_w > 10'sd127) ? 8'sd127 : (lod_w < -10'sd128) ? -8'sd128 : 8'(lod_w);
    if (lod_c < lod_min)
      lod_c = lod_min;
    if (lod_c > lod_max)
      lod_c = lod_max;
    // truncated lod picks the level; magnification and non-mip filters stay on base
    lvl_w = {1'b0, levels[3:0]};
    if (mip && lod_c > 8'sd0)
      lvl_w = {1'b0, levels[3:0]} + {2'b00, lod_c[6:4]};
    if (lvl_w > {1'b0, levels[7:4]})
      lvl_w = {1'b0, levels[7:4]};
    unique case (k)
      3'h0:    step = `ATS_STEP_N1;
      3'h1:    step = `ATS_STEP_N2;
      3'h2:    step = `ATS_STEP_N4;
      3'h3:    step = `ATS_STEP_N8;
      default: step = `ATS_STEP_N16;
    endcase
    off = $signed({1'b0, 13'(idx * step)}) - $signed(`ATS_HALF);
    du  = (axis_x ? f.dudx : f.dudy) * off;
    dv  = (axis_x ? f.dvdx : f.dvdy) * off;
  end

  always_comb
  begin
    next_st     = st;
    next_f      = f;
    next_k      = k;
    next_lvl    = lvl;
    next_lod    = lod;
    next_axis_x = axis_x;
    next_pm     = pm;
    next_idx    = idx;
    next_acc    = acc;
    next_result = result_data;
    frag_ready  = (st == ats_pkg::ST_IDLE);
    fetch_valid = (st == ats_pkg::ST_ISSUE);
    fetch.u     = f.u + 16'(du[23:8]);
    fetch.v     = f.v + 16'(dv[23:8]);
    fetch.level = lvl;
    result_valid = (st == ats_pkg::ST_DONE);
    unique case (st)
      ats_pkg::ST_IDLE:
        if (frag_valid)
        begin
          next_f  = frag;
          next_st = ats_pkg::ST_CALC;
        end
      ats_pkg::ST_CALC:
      begin
        next_k      = kc;
        next_lod    = lod_c;
        next_pm     = pmax;
        next_lvl    = lvl_w[3:0];
        next_axis_x = px > py;
        next_idx    = 5'h1;
        next_acc    = 48'h0;
        next_st     = ats_pkg::ST_ISSUE;
      end
      ats_pkg::ST_ISSUE:
        if (fetch_ready)
          next_st = ats_pkg::ST_WAIT;
      ats_pkg::ST_WAIT:
        if (texel_valid)
        begin
          for (int c = 0; c < 4; c++)
            next_acc[c*12 +: 12] = acc[c*12 +: 12] + {4'h0, texel_data[c*8 +: 8]};
          if (idx == (5'h1 << k))
          begin
            // equal weights: shift by log2 of the count
            for (int c = 0; c < 4; c++)
              next_result[c*8 +: 8] = 8'(next_acc[c*12 +: 12] >> k);
            next_st = ats_pkg::ST_DONE;
          end
          else
          begin
            next_idx = idx + 5'h1;
            next_st  = ats_pkg::ST_ISSUE;
          end
        end
      ats_pkg::ST_DONE:
        if (result_ready)
          next_st = ats_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st          <= ats_pkg::ST_IDLE;
      f           <= '0;
      k           <= 3'h0;
      lvl         <= 4'h0;
      lod         <= 8'sh00;
      axis_x      <= 1'b0;
      pm          <= 17'h0;
      idx         <= 5'h0;
      acc         <= 48'h0;
      result_data <= 32'h0;
    end
    else
    begin
      st          <= next_st;
      f           <= next_f;
      k           <= next_k;
      lvl         <= next_lvl;
      lod         <= next_lod;
      axis_x      <= next_axis_x;
      pm          <= next_pm;
      idx         <= next_idx;
      acc         <= next_acc;
      result_data <= next_result;
    end
  end

  // helper: fetches issued for the current fragment
  logic [4:0] n_fetch;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      n_fetch <= 5'h0;
    else if (st == ats_pkg::ST_CALC)
      n_fetch <= 5'h0;
    else if (fetch_valid && fetch_ready)
      n_fetch <= n_fetch + 5'h1;
  end

  sequence s_last_texel;
    st == ats_pkg::ST_WAIT && texel_valid && idx == (5'h1 << k);
  endsequence

  a_iso_one_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ats_pkg::ST_CALC && limit == `ATS_ONE) |=> (k == 3'h0))
    else $error("isotropic limit did not give one sample");
  a_count_capped: assert property (@(posedge hclk) disable iff (!hresetn)
    fetch_valid |-> ({4'h0, eff[11:4]} >= (12'h1 << k)) || k == 3'h0)
    else $error("sample count above effective limit");
  a_count_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
    st == ats_pkg::ST_ISSUE |-> ((({4'h0, pmin} << k) >= {4'h0, pm}) || k == 3'(MAX_K)
      || ({4'h0, eff[11:4]} < (12'h1 << (k + 3'h1)))))
    else $error("sample count below footprint ratio");
  a_base_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (fetch_valid && !mip) |-> fetch.level == levels[3:0])
    else $error("mip level read without mipmapped filter");
  a_level_range: assert property (@(posedge hclk) disable iff (!hresetn)
    fetch_valid |-> fetch.level <= levels[7:4] || fetch.level == levels[3:0])
    else $error("fetch level outside base..max");
  a_lod_clamped: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ats_pkg::ST_ISSUE && lod_min <= lod_max) |-> (lod >= lod_min && lod <= lod_max))
    else $error("lod outside clamp range");
  a_ceiling_two: assert property (@(posedge hclk) disable iff (!hresetn)
    CEILING >= `ATS_TWO)
    else $error("ceiling below two");
  a_scale_bounds: assert property (@(posedge hclk) disable iff (!hresetn)
    st == ats_pkg::ST_CALC |-> px >= {1'b0, ats_abs(f.dudx)} && px >= {1'b0, ats_abs(f.dvdx)}
      && px <= {1'b0, ats_abs(f.dudx)} + {1'b0, ats_abs(f.dvdx)})
    else $error("scale factor out of bounds");
  a_all_samples: assert property (@(posedge hclk) disable iff (!hresetn)
    s_last_texel |=> (st == ats_pkg::ST_DONE && n_fetch == (5'h1 << k)))
    else $error("result without exactly N fetches");
  a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (result_valid && !result_ready) |=> result_valid && $stable(result_data))
    else $error("result dropped before taken");
  a_major_axis: assert property (@(posedge hclk) disable iff (!hresetn)
    st == ats_pkg::ST_CALC |=> axis_x == ($past(px) > $past(py)))
    else $error("sample axis not the major one");
endmodule
`default_nettype wire

/* File: ats_mem_model.sv */
// Purpose: texel fetch memory model standing behind the sampler
// Assumes: one fetch outstanding at a time, answers in request order
// Notes:   texels alternate between two grey levels so any even average is known
`timescale 1ns/100ps
`default_nettype none
module ats_mem_model (
  input  wire logic                 hclk,        // clock
  input  wire logic                 hresetn,     // reset, active low
  input  wire logic                 slow,        // stall fetch and texel answers
  input  wire logic                 clr,         // restart counts for a fragment
  input  wire logic                 fetch_valid, // fetch offered
  input  wire ats_pkg::ats_fetch_s  fetch,       // fetch position and level
  output logic                      fetch_ready, // fetch taken
  output logic                      texel_valid, // texel answer pulse
  output logic [31:0]               texel_data,  // texel value
  output logic [4:0]                cnt,         // fetches this fragment
  output ats_pkg::ats_fetch_s       first,       // first fetch seen
  output ats_pkg::ats_fetch_s       last         // last fetch seen
);
  logic [2:0] fdly;
  logic [2:0] tdly;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fetch_ready <= 1'b0;
      texel_valid <= 1'b0;
      texel_data  <= 32'hA5A5A5A5;
      cnt         <= 5'h00;
      fdly        <= 3'h0;
      tdly        <= 3'h0;
      first       <= '0;
      last        <= '0;
    end
    else
    begin
      texel_valid <= 1'b0;
      // data is meaningless outside the answer pulse, so keep it moving
      texel_data  <= ~texel_data;
      if (fetch_valid && fetch_ready)
      begin
        fetch_ready <= 1'b0;
        last        <= fetch;
        if (cnt == 5'h00)
          first <= fetch;
        cnt  <= cnt + 5'h01;
        tdly <= slow ? 3'h4 : 3'h1;
      end
      else if (fetch_valid && fdly != 3'h0)
        fdly <= fdly - 3'h1;
      else if (fetch_valid)
        fetch_ready <= 1'b1;
      else
        fdly <= slow ? 3'h3 : 3'h0;
      if (tdly == 3'h1)
      begin
        texel_valid <= 1'b1;
        texel_data  <= cnt[0] ? 32'h20202020 : 32'h40404040;
      end
      if (tdly != 3'h0)
        tdly <= tdly - 3'h1;
      if (clr)
        cnt <= 5'h00;
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench for the anisotropic sampler
// Assumes: ceiling 16.0, up to 16 samples, zero-wait bus slave
// Notes:   first texel of a fragment is 0x20 per channel, then 0x40, alternating
`include "ats_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic                frag_valid;
  ats_pkg::ats_frag_s  frag;
  logic                frag_ready;
  logic                fetch_valid;
  ats_pkg::ats_fetch_s fetch;
  logic                fetch_ready;
  logic                texel_valid;
  logic [31:0]         texel_data;
  logic                result_valid;
  logic [31:0]         result_data;
  logic                result_ready;
  logic                slow;
  logic                clr;
  logic [4:0]          cnt;
  ats_pkg::ats_fetch_s first;
  ats_pkg::ats_fetch_s last;
  logic [31:0]         rd;
  int                  err_count;
  int                  checks_done;

  ats_sampler #(.CEILING(12'h100), .MAX_K(4)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frag_valid(frag_valid),
    .frag(frag), .frag_ready(frag_ready), .fetch_valid(fetch_valid), .fetch(fetch),
    .fetch_ready(fetch_ready), .texel_valid(texel_valid), .texel_data(texel_data),
    .result_valid(result_valid), .result_data(result_data), .result_ready(result_ready));

  ats_mem_model mem (
    .hclk(hclk), .hresetn(hresetn), .slow(slow), .clr(clr), .fetch_valid(fetch_valid),
    .fetch(fetch), .fetch_ready(fetch_ready), .texel_valid(texel_valid),
    .texel_data(texel_data), .cnt(cnt), .first(first), .last(last));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task stop_test;
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    check(n, rd, e);
  endtask

  task run_frag(input logic [15:0] dx, input logic [15:0] vy, input logic sl,
                input logic [4:0] n, input logic [3:0] lvl, input logic ydir);
    clr  <= 1'b1;
    slow <= sl;
    @(posedge hclk);
    clr        <= 1'b0;
    frag_valid <= 1'b1;
    frag       <= {dx, 16'h0, 16'h0, vy, 16'h4000, 16'h4000};
    do @(posedge hclk); while (frag_ready !== 1'b1);
    frag_valid <= 1'b0;
    // hold off one cycle so the result must stand while not taken
    do @(posedge hclk); while (result_valid !== 1'b1);
    result_ready <= 1'b1;
    @(posedge hclk);
    check("held", {31'h0, result_valid}, 32'h1);
    result_ready <= 1'b0;
    check("samples", {27'h0, cnt}, {27'h0, n});
    check("result", result_data, n == 5'h01 ? 32'h20202020 : 32'h30303030);
    check("level", {28'h0, last.level}, {28'h0, lvl});
    if (n != 5'h01)
      check("axis", ydir ? {29'h0, first.u == 16'h4000, first.v < 16'h4000, last.v > 16'h4000} :
            {29'h0, first.v == 16'h4000, first.u < 16'h4000, last.u > 16'h4000}, 32'h7);
  endtask

  task reg_test;
    rchk("limit", `ATS_OFS_LIMIT, 32'h010);
    rchk("filter", `ATS_OFS_FILTER, 32'h1);
    rchk("levels", `ATS_OFS_LEVELS, 32'hF0);
    rchk("lodclmp", `ATS_OFS_LODCLMP, 32'h7F80);
    rchk("ceiling", `ATS_OFS_CEILING, 32'h100);
    ahb(1'b1, `ATS_OFS_CEILING, 32'h0, rd);
    rchk("ceiling_ro", `ATS_OFS_CEILING, 32'h100);
    ahb(1'b1, 8'h18, 32'hFFFF, rd);
    rchk("unmapped", 8'h18, 32'h0);
  endtask

  task aniso_test;
    run_frag(16'h0400, 16'h0100, 1'b0, 5'h01, 4'h2, 1'b0);
    ahb(1'b1, `ATS_OFS_LIMIT, 32'h040, rd);
    run_frag(16'h0400, 16'h0100, 1'b0, 5'h04, 4'h0, 1'b0);
    run_frag(16'h0100, 16'h0400, 1'b1, 5'h04, 4'h0, 1'b1);
    ahb(1'b1, `ATS_OFS_LIMIT, 32'h030, rd);
    run_frag(16'h0400, 16'h0100, 1'b0, 5'h02, 4'h1, 1'b0);
    ahb(1'b1, `ATS_OFS_LIMIT, 32'h100, rd);
    run_frag(16'h0300, 16'h0100, 1'b1, 5'h04, 4'h0, 1'b0);
    run_frag(16'h1000, 16'h0100, 1'b0, 5'h10, 4'h0, 1'b0);
  endtask

  task level_test;
    ahb(1'b1, `ATS_OFS_LIMIT, 32'h010, rd);
    run_frag(16'h1000, 16'h1000, 1'b0, 5'h01, 4'h4, 1'b0);
    ahb(1'b1, `ATS_OFS_LEVELS, 32'h52, rd);
    run_frag(16'h1000, 16'h1000, 1'b0, 5'h01, 4'h5, 1'b0);
    ahb(1'b1, `ATS_OFS_FILTER, 32'h0, rd);
    run_frag(16'h1000, 16'h1000, 1'b1, 5'h01, 4'h2, 1'b0);
    ahb(1'b1, `ATS_OFS_FILTER, 32'h1, rd);
    ahb(1'b1, `ATS_OFS_LODCLMP, 32'h2080, rd);
    run_frag(16'h1000, 16'h1000, 1'b0, 5'h01, 4'h4, 1'b0);
    rchk("status", `ATS_OFS_STATUS, 32'h00200400);
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    frag_valid = 1'b0;
    frag = '0;
    result_ready = 1'b0;
    slow = 1'b0;
    clr = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reg_test;
    aniso_test;
    level_test;
    stop_test;
  end

  // the whole run needs a few hundred cycles; this leaves wide margin
  initial
  begin
    #500000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
